// *** common/ccs_pkg.sv ***
`default_nettype none
package ccs_pkg;
    // ----------------------------------------
    // register map (attribute memory byte addresses)
    // ----------------------------------------
    localparam logic [10:0] ADDR_CONDITION = 11'h202;
    localparam logic [10:0] ADDR_PIN_REPL = 11'h204;
    localparam logic [10:0] ADDR_SOCKET = 11'h206;

    // ----------------------------------------
    // card_condition_status fields
    // ----------------------------------------
    localparam int CCS_CHANGED_BIT = 7;
    localparam int CCS_CHG_EN_BIT = 6;
    localparam int CCS_IO8_BIT = 5;
    localparam int CCS_PWRDN_BIT = 2;
    localparam int CCS_INT_BIT = 1;

    // ----------------------------------------
    // pin_replacement_flags fields
    // ----------------------------------------
    localparam int PRF_RDY_CHG_BIT = 5;
    localparam int PRF_WP_CHG_BIT = 4;
    localparam int PRF_ONE3_BIT = 3;
    localparam int PRF_ONE2_BIT = 2;
    localparam int PRF_RDY_BIT = 1;
    localparam int PRF_WP_BIT = 0;

    // ----------------------------------------
    // socket_and_copy_info fields
    // ----------------------------------------
    localparam int SCI_DRIVE_BIT = 4;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic RST_CHG_EN = 1'b0;
    localparam logic RST_IO8 = 1'b0;
    localparam logic RST_PWRDN = 1'b0;
    localparam logic RST_DRIVE = 1'b0;
    localparam logic RST_FLAG = 1'b0;

    // ----------------------------------------
    // power transition time, in cycles of CORE_CLK
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int PWR_SETTLE_NS = 1000;
    localparam int PWR_SETTLE_CYC = (PWR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_NS = 10000;
    localparam int IDLE_CYC = IDLE_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // attribute bus request toward the register bank
    // ----------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [10:0] addr;
        logic [7:0] wdata;
    } ccs_req_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_TO_SLEEP,
        PWR_SLEEP,
        PWR_TO_ACTIVE
    } ccs_pwr_t;
endpackage
`default_nettype wire

// *** core/ccs_power_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccs_power_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic power_down_request,
    input wire logic cmd_arrive,
    input wire logic core_idle,
    output logic sleeping,
    output logic busy
);
    import ccs_pkg::*;

    ccs_pwr_t state;
    logic [15:0] cnt;
    logic req_q;
    logic req_edge;
    logic idle_hit;

    assign req_edge = power_down_request ^ req_q;
    assign idle_hit = (cnt == 16'(IDLE_CYC - 1));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_q <= 1'b0;
        end else begin
            req_q <= power_down_request;
        end
    end

    // a request change always restarts the transition so ready waits for the new state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= PWR_ACTIVE;
            cnt <= 16'h0000;
        end else if (req_edge) begin
            state <= power_down_request ? PWR_TO_SLEEP : PWR_TO_ACTIVE;
            cnt <= 16'h0000;
        end else begin
            unique case (state)
                PWR_ACTIVE: begin
                    // auto sleep on idle, independent of the request bit
                    if (!core_idle || cmd_arrive) begin
                        cnt <= 16'h0000;
                    end else if (idle_hit) begin
                        state <= PWR_SLEEP;
                        cnt <= 16'h0000;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                PWR_TO_SLEEP, PWR_TO_ACTIVE: begin
                    if (cnt == 16'(PWR_SETTLE_CYC - 1)) begin
                        state <= (state == PWR_TO_SLEEP) ? PWR_SLEEP : PWR_ACTIVE;
                        cnt <= 16'h0000;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                PWR_SLEEP: begin
                    if (cmd_arrive) begin
                        state <= PWR_TO_ACTIVE;
                        cnt <= 16'h0000;
                    end
                end
            endcase
        end
    end

    assign sleeping = (state == PWR_SLEEP);
    assign busy = (state == PWR_TO_SLEEP) || (state == PWR_TO_ACTIVE) || req_edge;
endmodule
`default_nettype wire

// *** core/ccs_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - registers decode at attribute addresses 202h, 204h and 206h.
// - changed bit reads one when either change flag is set.
// - status-change pin low when changed, enabled and configured for I/O.
// - with enable clear, status-change pin stays high while in I/O mode.
// - status-change enable is stored and read back.
// - eight-bit I/O request accepted but ignored; both widths always work.
// - power-down bit one enters power save, zero returns to active.
// - any power-down bit change shows busy until the new state is reached.
// - card sleeps itself when idle and wakes on a new command.
// - interrupt bit mirrors internal request until serviced, in any mode.
// - interrupt bit reads zero while interrupts are disabled.
// - ready change flag sets when live ready/busy toggles; host may write.
// - protect change flag sets when live write-protect toggles; host may write.
// - live write-protect reads zero; no protect switch exists.
// - mask bit one loads the written value into its change flag.
// - mask bit zero leaves its change flag untouched.
// - drive-number bit is stored and read back.
// - socket-number bits are ignored and read zero.
// - accesses are byte wide at even addresses, even byte only.
module ccs_regs (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire ccs_pkg::ccs_req_t REQ,
    input wire logic IO_CONFIGURED,
    input wire logic INT_REQUEST,
    input wire logic INTERRUPT_DISABLE_N,
    input wire logic CORE_READY,
    input wire logic CMD_ARRIVE,
    input wire logic CORE_IDLE,
    output logic [7:0] RDATA,
    output logic STATUS_CHANGE_OUT_N,
    output logic READY_OUT,
    output logic POWER_SAVE,
    output logic DRIVE_NUMBER
);
    import ccs_pkg::*;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic logic hit(input ccs_req_t r, input logic [10:0] a);
        // odd addresses never match, so odd accesses fall through untouched
        return r.addr == a;
    endfunction

    logic wr_ccs;
    logic wr_prf;
    logic wr_sci;
    assign wr_ccs = REQ.wr && hit(REQ, ADDR_CONDITION);
    assign wr_prf = REQ.wr && hit(REQ, ADDR_PIN_REPL);
    assign wr_sci = REQ.wr && hit(REQ, ADDR_SOCKET);

    // ----------------------------------------
    // stored control bits
    // ----------------------------------------
    logic status_change_enable;
    logic eight_bit_io_request;
    logic power_down_request;
    logic drive_number;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            status_change_enable <= RST_CHG_EN;
            eight_bit_io_request <= RST_IO8;
            power_down_request <= RST_PWRDN;
        end else if (wr_ccs) begin
            status_change_enable <= REQ.wdata[CCS_CHG_EN_BIT];
            // stored for readback only, the data path always handles both widths
            eight_bit_io_request <= REQ.wdata[CCS_IO8_BIT];
            power_down_request <= REQ.wdata[CCS_PWRDN_BIT];
        end
    end

    // reserved and socket-number bits are dropped on write
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            drive_number <= RST_DRIVE;
        end else if (wr_sci) begin
            drive_number <= REQ.wdata[SCI_DRIVE_BIT];
        end
    end

    // ----------------------------------------
    // power control
    // ----------------------------------------
    logic sleeping;
    logic pwr_busy;

    ccs_power_ctrl u_pwr (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .power_down_request(power_down_request),
        .cmd_arrive(CMD_ARRIVE),
        .core_idle(CORE_IDLE),
        .sleeping(sleeping),
        .busy(pwr_busy)
    );

    // ----------------------------------------
    // live pin states and change flags
    // ----------------------------------------
    logic live_ready_busy;
    logic live_write_protect;
    logic live_ready_q;
    logic live_wp_q;
    logic ready_change_flag;
    logic protect_change_flag;
    logic ready_change_mask;
    logic protect_change_mask;

    assign live_ready_busy = CORE_READY && !pwr_busy;
    assign live_write_protect = 1'b0;
    assign ready_change_mask = REQ.wdata[PRF_RDY_BIT];
    assign protect_change_mask = REQ.wdata[PRF_WP_BIT];

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            live_ready_q <= 1'b1;
            live_wp_q <= 1'b0;
        end else begin
            live_ready_q <= live_ready_busy;
            live_wp_q <= live_write_protect;
        end
    end

    // a hardware toggle beats a host clear in the same cycle
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ready_change_flag <= RST_FLAG;
        end else if (live_ready_busy != live_ready_q) begin
            ready_change_flag <= 1'b1;
        end else if (wr_prf && ready_change_mask) begin
            ready_change_flag <= REQ.wdata[PRF_RDY_CHG_BIT];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            protect_change_flag <= RST_FLAG;
        end else if (live_write_protect != live_wp_q) begin
            protect_change_flag <= 1'b1;
        end else if (wr_prf && protect_change_mask) begin
            protect_change_flag <= REQ.wdata[PRF_WP_CHG_BIT];
        end
    end

    // ----------------------------------------
    // derived status
    // ----------------------------------------
    logic changed;
    logic int_pending;
    assign changed = ready_change_flag || protect_change_flag;
    assign int_pending = INT_REQUEST && INTERRUPT_DISABLE_N;

    // ----------------------------------------
    // read path
    // ----------------------------------------
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (REQ.rd && hit(REQ, ADDR_CONDITION)) begin
            next_rdata[CCS_CHANGED_BIT] = changed;
            next_rdata[CCS_CHG_EN_BIT] = status_change_enable;
            next_rdata[CCS_IO8_BIT] = eight_bit_io_request;
            next_rdata[CCS_PWRDN_BIT] = power_down_request;
            next_rdata[CCS_INT_BIT] = int_pending;
        end else if (REQ.rd && hit(REQ, ADDR_PIN_REPL)) begin
            next_rdata[PRF_RDY_CHG_BIT] = ready_change_flag;
            next_rdata[PRF_WP_CHG_BIT] = protect_change_flag;
            next_rdata[PRF_ONE3_BIT] = 1'b1;
            next_rdata[PRF_ONE2_BIT] = 1'b1;
            next_rdata[PRF_RDY_BIT] = live_ready_busy;
            next_rdata[PRF_WP_BIT] = live_write_protect;
        end else if (REQ.rd && hit(REQ, ADDR_SOCKET)) begin
            next_rdata[SCI_DRIVE_BIT] = drive_number;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    // outside I/O mode the pin is released high; in memory mode it carries no status
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            STATUS_CHANGE_OUT_N <= 1'b1;
        end else begin
            STATUS_CHANGE_OUT_N <= !(changed && status_change_enable && IO_CONFIGURED);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            READY_OUT <= 1'b0;
            POWER_SAVE <= 1'b0;
            DRIVE_NUMBER <= 1'b0;
        end else begin
            READY_OUT <= live_ready_busy;
            POWER_SAVE <= sleeping;
            DRIVE_NUMBER <= drive_number;
        end
    end
endmodule
`default_nettype wire

// *** dv/ccs_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccs_host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output ccs_pkg::ccs_req_t req
);
    import ccs_pkg::*;
    initial req = '0;
    // socket byte goes out with its top bit forced low, other bytes as given
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= {1'b0, 1'b1, a, (a == ADDR_SOCKET) ? {1'b0, d[6:0]} : d};
        @(posedge clk);
        req <= '0;
    endtask
    // one byte per access, strobe held for exactly one taken edge
    task automatic rd(input logic [10:0] a, output logic [7:0] q);
        @(posedge clk);
        req <= {1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        req <= '0;
        #1 q = rdata;
    endtask
endmodule
`default_nettype wire

// *** dv/ccs_regs_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccs_regs_checker (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire ccs_pkg::ccs_req_t REQ,
    input wire logic IO_CONFIGURED,
    input wire logic INT_REQUEST,
    input wire logic INTERRUPT_DISABLE_N,
    input wire logic [7:0] RDATA,
    input wire logic STATUS_CHANGE_OUT_N,
    input wire logic READY_OUT,
    input wire logic POWER_SAVE,
    input wire logic DRIVE_NUMBER
);
    import ccs_pkg::*;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    logic en_q;
    logic pd_q;
    wire logic rd_c = REQ.rd && REQ.addr == ADDR_CONDITION;
    wire logic rd_p = REQ.rd && REQ.addr == ADDR_PIN_REPL;
    wire logic rd_s = REQ.rd && REQ.addr == ADDR_SOCKET;
    wire logic wr_c = REQ.wr && REQ.addr == ADDR_CONDITION;
    wire logic wr_s = REQ.wr && REQ.addr == ADDR_SOCKET;
    // shadow of host-written bits, needed because the bank is not visible
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            en_q <= 1'b0;
            pd_q <= 1'b0;
        end else if (wr_c) begin
            en_q <= REQ.wdata[6];
            pd_q <= REQ.wdata[2];
        end
    end
    chk_unmapped_zero: assert property (REQ.rd && !rd_c && !rd_p && !rd_s |=> RDATA == 8'h00)
        else $error("unmapped read gave data");
    chk_pin_fixed: assert property (rd_p |=> RDATA[7:6] == 2'h0 && RDATA[3:2] == 2'h3 && !RDATA[0])
        else $error("pin register fixed bits wrong");
    chk_socket_bits: assert property (rd_s |=> RDATA[6:5] == 2'h0 && RDATA[3:0] == 4'h0)
        else $error("socket fixed bits wrong");
    // the pin sits one flop behind the stored bit, so it shows two edges after the write
    chk_drive_store: assert property (wr_s |=> ##1 DRIVE_NUMBER == $past(REQ.wdata[4], 2))
        else $error("drive bit not stored");
    chk_int_mask: assert property (rd_c && !INTERRUPT_DISABLE_N |=> !RDATA[1])
        else $error("int bit set while disabled");
    chk_int_live: assert property (rd_c && INT_REQUEST && INTERRUPT_DISABLE_N
        && $stable(INT_REQUEST) && $stable(INTERRUPT_DISABLE_N) |=> RDATA[1])
        else $error("int bit missing");
    chk_pin_quiet: assert property (IO_CONFIGURED && !en_q |=> STATUS_CHANGE_OUT_N)
        else $error("status pin low while disabled");
    chk_pin_cause: assert property (!STATUS_CHANGE_OUT_N |-> $past(IO_CONFIGURED) && $past(en_q))
        else $error("status pin low without cause");
    chk_busy_hold: assert property (wr_c && REQ.wdata[2] != pd_q |-> ##2 (!READY_OUT) [*8])
        else $error("ready during power change");
    chk_sleep_enter: assert property (wr_c && REQ.wdata[2] && !pd_q |-> ##[1:50] POWER_SAVE)
        else $error("no power save after request");
    cover property (!STATUS_CHANGE_OUT_N);
    cover property (POWER_SAVE);
    cover property (rd_p ##1 RDATA[5]);
endmodule
bind ccs_regs ccs_regs_checker ccs_regs_checker_inst (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .REQ(REQ), .IO_CONFIGURED(IO_CONFIGURED),
    .INT_REQUEST(INT_REQUEST), .INTERRUPT_DISABLE_N(INTERRUPT_DISABLE_N), .RDATA(RDATA),
    .STATUS_CHANGE_OUT_N(STATUS_CHANGE_OUT_N), .READY_OUT(READY_OUT),
    .POWER_SAVE(POWER_SAVE), .DRIVE_NUMBER(DRIVE_NUMBER)
);
`default_nettype wire

// *** dv/card_config_status_regs_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module card_config_status_regs_tb;
    import ccs_pkg::*;
    logic clk;
    logic rst_n = 1'b0;
    logic io_cfg = 1'b0;
    logic int_req = 1'b0;
    logic int_dis_n = 1'b1;
    logic core_rdy = 1'b1;
    logic cmd = 1'b0;
    logic idle = 1'b0;
    logic [7:0] rdata;
    logic sts_n;
    logic rdy_out;
    logic psave;
    logic drive;
    logic [7:0] q;
    int errors = 0;
    int tests_run = 0;
    ccs_req_t req;
    // {address, byte written, byte read back}
    logic [26:0] rows [0:9] = '{
        {ADDR_CONDITION, 8'h60, 8'h60}, {ADDR_CONDITION, 8'h00, 8'h00},
        {ADDR_PIN_REPL, 8'hff, 8'h3e}, {ADDR_PIN_REPL, 8'h20, 8'h3e},
        {ADDR_PIN_REPL, 8'h03, 8'h0e}, {ADDR_PIN_REPL, 8'h12, 8'h0e},
        {ADDR_SOCKET, 8'h9f, 8'h10}, {ADDR_SOCKET, 8'h0f, 8'h00},
        {11'h203, 8'hff, 8'h00}, {11'h208, 8'hff, 8'h00}};
    ccs_regs ccs_regs_inst (
        .CORE_CLK(clk), .RST_N(rst_n), .REQ(req), .IO_CONFIGURED(io_cfg),
        .INT_REQUEST(int_req), .INTERRUPT_DISABLE_N(int_dis_n), .CORE_READY(core_rdy),
        .CMD_ARRIVE(cmd), .CORE_IDLE(idle), .RDATA(rdata), .STATUS_CHANGE_OUT_N(sts_n),
        .READY_OUT(rdy_out), .POWER_SAVE(psave), .DRIVE_NUMBER(drive));
    ccs_host_model host_inst (.clk(clk), .rdata(rdata), .req(req));
    task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic rchk(input logic [10:0] a, input logic [7:0] exp);
        host_inst.rd(a, q);
        chk("read data", exp, q);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        wt(5);
        rst_n <= 1'b1;
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // the whole run needs under a thousand cycles
    initial begin
        wt(5000);
        errors++;
        summarize();
    end
    initial begin
        do_reset();
        foreach (rows[i]) begin
            host_inst.wr(rows[i][26:16], rows[i][15:8]);
            rchk(rows[i][26:16], rows[i][7:0]);
        end
        $display("test rows done");
        wt(1);
        io_cfg <= 1'b1;
        host_inst.wr(ADDR_CONDITION, 8'h40);
        // ready flag value in bit 5, its mask in bit 1
        host_inst.wr(ADDR_PIN_REPL, 8'h22);
        rchk(ADDR_CONDITION, 8'hc0);
        chk("status pin", 8'h00, sts_n);
        wt(1);
        io_cfg <= 1'b0;
        wt(2);
        #1 chk("status pin", 8'h01, sts_n);
        wt(1);
        io_cfg <= 1'b1;
        host_inst.wr(ADDR_PIN_REPL, 8'h02);
        wt(2);
        #1 chk("status pin", 8'h01, sts_n);
        host_inst.wr(ADDR_CONDITION, 8'h00);
        host_inst.wr(ADDR_PIN_REPL, 8'h22);
        wt(2);
        #1 chk("status pin", 8'h01, sts_n);
        host_inst.wr(ADDR_PIN_REPL, 8'h02);
        $display("test status pin done");
        wt(1);
        int_req <= 1'b1;
        rchk(ADDR_CONDITION, 8'h02);
        wt(1);
        int_dis_n <= 1'b0;
        rchk(ADDR_CONDITION, 8'h00);
        wt(1);
        int_req <= 1'b0;
        int_dis_n <= 1'b1;
        $display("test interrupt bit done");
        host_inst.wr(ADDR_CONDITION, 8'h04);
        wt(3);
        #1 chk("ready pin", 8'h00, rdy_out);
        wt(45);
        #1 chk("sleep pin", 8'h01, psave);
        chk("ready pin", 8'h01, rdy_out);
        rchk(ADDR_PIN_REPL, 8'h2e);
        host_inst.wr(ADDR_CONDITION, 8'h00);
        wt(45);
        #1 chk("sleep pin", 8'h00, psave);
        $display("test power request done");
        wt(1);
        idle <= 1'b1;
        wt(410);
        #1 chk("sleep pin", 8'h01, psave);
        wt(1);
        idle <= 1'b0;
        cmd <= 1'b1;
        wt(1);
        cmd <= 1'b0;
        wt(45);
        #1 chk("sleep pin", 8'h00, psave);
        $display("test idle sleep done");
        host_inst.wr(ADDR_PIN_REPL, 8'h03);
        core_rdy <= 1'b0;
        rchk(ADDR_PIN_REPL, 8'h2c);
        rchk(ADDR_CONDITION, 8'h80);
        $display("test ready change done");
        host_inst.wr(ADDR_SOCKET, 8'h10);
        core_rdy <= 1'b1;
        wt(2);
        #1 chk("drive pin", 8'h01, drive);
        do_reset();
        #1 chk("status pin", 8'h01, sts_n);
        chk("sleep pin", 8'h00, psave);
        chk("drive pin", 8'h00, drive);
        rchk(ADDR_CONDITION, 8'h00);
        rchk(ADDR_PIN_REPL, 8'h0e);
        rchk(ADDR_SOCKET, 8'h00);
        $display("test reset done");
        summarize();
    end
endmodule
`default_nettype wire
